// ### rtl/tsr_test_signal_routing.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tsr_defines.svh"

// Overview of operation
// - Chosen test bus bit drives modulation pin
// - Aux select all-ones also drives auxiliary pin
// - Group select field picks the test bus
// - Swap bit reorders bus onto data pins
// - PRBS9 bit enables and seeds nine-stage generator
// - PRBS15 bit enables and seeds fifteen-stage generator
// - Sequence transmits only after transmit command
// - Line enable zero disables extra UART lines
// - Each enable bit drives matching data pin
// - SPI host limits test outputs to D1-D4
// - UART with lines enabled limits D1-D4
// - Readback register shows selected test bus
module tsr_test_signal_routing (
   input wire logic clk_sys,
   input wire logic reset,
   input wire tsr_pkg::tsr_axi_req_type axiReq,
   output tsr_pkg::tsr_axi_resp_type axiResp,
   input wire tsr_pkg::tsr_groups_type testGroups,
   input wire logic uartExtraData,
   input wire logic uartRequestData,
   output tsr_pkg::tsr_pins_type pins
);
   import tsr_pkg::*;

   // Whole block state, registered in one place
   typedef struct packed {
      tsr_axi_resp_type bus; // Bus answers
      logic awHeld; // Write address taken
      logic [31:0] awAddr;
      logic wHeld; // Write data taken
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic [2:0] bitSel; // test_bit_select
      logic [7:0] groupCtl; // Swap, PRBS bits, group
      logic [7:0] pinEn; // Line enable, pin enables
      logic [3:0] auxSel; // Second aux analog select
      tsr_host_type hostMode; // Host interface in use
      logic [8:0] prbs9; // Nine-stage shift register
      logic [14:0] prbs15; // Fifteen-stage shift register
      logic txRun; // Sequence transmitting
      tsr_pins_type pins; // Pin outputs
   } tsr_state_type;

   tsr_state_type st; // Current state
   tsr_state_type next_st; // Next state

   // Address decode shared by write and read paths
   function automatic tsr_sel_type decodeAddr(
      input logic [31:0] addr
   );
      logic [7:0] idx;
      // Word index sits in bits 9:2
      idx = addr[9:2];
      // Anything above the page of indices is unmapped
      if (addr[31:10] != 22'h0) begin
         decodeAddr = SEL_NONE;
      end else if (idx == `TSR_IDX_RESERVED) begin
         decodeAddr = SEL_RESERVED;
      end else if (idx == `TSR_IDX_BITSEL) begin
         decodeAddr = SEL_BITSEL;
      end else if (idx == `TSR_IDX_GROUPCTL) begin
         decodeAddr = SEL_GROUPCTL;
      end else if (idx == `TSR_IDX_PINEN) begin
         decodeAddr = SEL_PINEN;
      end else if (idx == `TSR_IDX_BUSREAD) begin
         decodeAddr = SEL_BUSREAD;
      end else if (idx == `TSR_IDX_AUXCTL) begin
         decodeAddr = SEL_AUXCTL;
      end else begin
         decodeAddr = SEL_NONE;
      end
   endfunction

   // Selected group of the internal test bus
   logic [7:0] testBus;
   assign testBus = testGroups[st.groupCtl[4:0]];

   // Next-state logic for bus, registers, generators, pins
   always_comb begin
      // Scratch values, each given a value first so nothing latches
      logic [7:0] wByte;
      logic [7:0] rByte;
      logic txCmd;
      logic modeOn;
      logic [5:0] mapped;
      logic [5:0] allowed;
      tsr_sel_type wSel;
      tsr_sel_type rSel;
      // Defaults on every path
      wByte = 8'h00;
      rByte = 8'h00;
      txCmd = 1'b0;
      modeOn = 1'b0;
      mapped = 6'h00;
      allowed = 6'h00;
      wSel = SEL_NONE;
      rSel = SEL_NONE;
      next_st = st;

      // Address and data may arrive in either order
      if (axiReq.awvalid && st.bus.awready) begin
         next_st.awHeld = 1'b1;
         next_st.awAddr = axiReq.awaddr;
      end
      // Data lane captured with its strobes
      if (axiReq.wvalid && st.bus.wready) begin
         next_st.wHeld = 1'b1;
         next_st.wData = axiReq.wdata;
         next_st.wStrb = axiReq.wstrb;
      end

      // Response handshake retires the write
      if (st.bus.bvalid && axiReq.bready) begin
         next_st.bus.bvalid = 1'b0;
      end

      // Both halves held: perform the write
      if (st.awHeld && st.wHeld && !st.bus.bvalid) begin
         // Write lands on this edge; response raised with it
         wSel = decodeAddr(st.awAddr);
         wByte = st.wData[7:0];
         next_st.awHeld = 1'b0;
         next_st.wHeld = 1'b0;
         next_st.bus.bvalid = 1'b1;
         next_st.bus.bresp = `TSR_RESP_OKAY;
         if (wSel == SEL_NONE) begin
            // Unmapped: error answer, nothing stored
            next_st.bus.bresp = `TSR_RESP_SLVERR;
         end else if (!st.wStrb[0]) begin
            // Low lane not strobed: nothing to store
            next_st.bus.bresp = `TSR_RESP_OKAY;
         end else if (wSel == SEL_BITSEL) begin
            // Upper five bits are dropped
            next_st.bitSel = wByte[2:0];
         end else if (wSel == SEL_GROUPCTL) begin
            // Swap, sequence bits and group in one go
            next_st.groupCtl = wByte;
            // Rising mode bit reseeds and waits
            if (wByte[`TSR_F_PRBS9]
                && !st.groupCtl[`TSR_F_PRBS9]) begin
               next_st.prbs9 = `TSR_SEED9;
               next_st.txRun = 1'b0;
            end
            if (wByte[`TSR_F_PRBS15]
                && !st.groupCtl[`TSR_F_PRBS15]) begin
               next_st.prbs15 = `TSR_SEED15;
               next_st.txRun = 1'b0;
            end
         end else if (wSel == SEL_PINEN) begin
            // Bit zero is reserved and stays clear
            next_st.pinEn = {wByte[7:1], 1'b0};
         end else if (wSel == SEL_AUXCTL) begin
            next_st.auxSel = wByte[3:0];
            next_st.hostMode = tsr_host_type'(wByte[5:4]);
            // Transmit bit acts once and is not stored
            txCmd = wByte[`TSR_F_TXCMD];
         end
         // Reserved slot and readback ignore writes
      end

      // Read channel: one outstanding read
      if (st.bus.rvalid && axiReq.rready) begin
         next_st.bus.rvalid = 1'b0;
      end
      // Address taken: answer on the next edge
      if (axiReq.arvalid && st.bus.arready) begin
         rSel = decodeAddr(axiReq.araddr);
         next_st.bus.rvalid = 1'b1;
         next_st.bus.rresp = `TSR_RESP_OKAY;
         if (rSel == SEL_BITSEL) begin
            // Upper five bits are reserved
            rByte = {5'h00, st.bitSel};
         end else if (rSel == SEL_GROUPCTL) begin
            // Stored as written, all eight bits
            rByte = st.groupCtl;
         end else if (rSel == SEL_PINEN) begin
            // Bit zero was cleared when written
            rByte = st.pinEn;
         end else if (rSel == SEL_BUSREAD) begin
            // Live group value, not a stored copy
            rByte = testBus;
         end else if (rSel == SEL_AUXCTL) begin
            // Transmit command bit reads as zero
            rByte = {2'h0, st.hostMode, st.auxSel};
         end else if (rSel == SEL_RESERVED) begin
            rByte = 8'h00;
         end else begin
            // Unmapped: error answer, data stays zero
            next_st.bus.rresp = `TSR_RESP_SLVERR;
         end
         next_st.bus.rdata = {24'h000000, rByte};
      end

      // Sequence generators run only after transmit
      // Either mode bit keeps the generators armed
      modeOn = next_st.groupCtl[`TSR_F_PRBS9]
               || next_st.groupCtl[`TSR_F_PRBS15];
      if (!modeOn) begin
         next_st.txRun = 1'b0;
      end else if (txCmd) begin
         next_st.txRun = 1'b1;
      end
      // Shift from the edge after the transmit command on
      if (st.txRun && next_st.txRun) begin
         // x^9 + x^5 + 1
         next_st.prbs9 = {st.prbs9[7:0],
                          st.prbs9[8] ^ st.prbs9[4]};
         // x^15 + x^14 + 1
         next_st.prbs15 = {st.prbs15[13:0],
                           st.prbs15[14] ^ st.prbs15[13]};
      end
      // Nine-stage wins when both modes are set
      if (next_st.groupCtl[`TSR_F_PRBS9]) begin
         next_st.pins.prbsBit = next_st.prbs9[8];
      end else begin
         next_st.pins.prbsBit = next_st.prbs15[14];
      end
      // Tells test equipment the sequence is on the line
      next_st.pins.prbsActive = next_st.txRun;

      // Routing pins follow the registers as they stood before this
      // edge, so group, bit and swap always change together and the
      // pins trail a register write by exactly one clock
      // Chosen bit onto modulation and aux pins
      next_st.pins.modulationOutputPin = testBus[st.bitSel];
      // Aux pin carries the same bit; only its driver is gated
      next_st.pins.auxiliaryPinTwo = testBus[st.bitSel];
      next_st.pins.auxiliaryPinTwoOe =
         (st.auxSel == `TSR_AUXILIARY_PIN_TWO_TESTBIT);

      // Data pin order, D1 first
      if (st.groupCtl[`TSR_F_SWAP]) begin
         // Swapped: D1 to D6 carry bits 4, 3, 2, 6, 5, 0
         mapped = {testBus[0], testBus[5], testBus[6],
                   testBus[2], testBus[3], testBus[4]};
      end else begin
         // Plain: Dn carries bit n, bit 7 has no pin
         mapped = testBus[6:1];
      end
      next_st.pins.dataPinOut = mapped;

      // SPI, and UART with line enable set, keep D5 and D6 for themselves
      if (st.hostMode == HOST_SPI) begin
         // SPI owns the upper data pins
         allowed = `TSR_PINS_LIMITED;
      end else if (st.hostMode == HOST_UART
                   && st.pinEn[`TSR_F_LINEEN]) begin
         // Extra UART lines borrow the upper data pins
         allowed = `TSR_PINS_LIMITED;
      end else begin
         // Parallel or two-wire host, or UART with line enable clear: all six pins usable
         allowed = `TSR_PINS_ALL;
      end
      // A pin drives only if enabled and not taken by the host
      next_st.pins.dataPinOe =
         st.pinEn[6:1] & allowed;

      // Extra UART lines follow the line enable
      // Held low while off, so no stale level is left on them
      next_st.pins.uartLinesOe =
         st.pinEn[`TSR_F_LINEEN];
      next_st.pins.uartExtraOutputLine =
         uartExtraData & st.pinEn[`TSR_F_LINEEN];
      next_st.pins.uartRequestLine =
         uartRequestData & st.pinEn[`TSR_F_LINEEN];

      // A new write waits until the last response is taken
      // Ready only while the matching slot is free
      next_st.bus.awready = !next_st.awHeld
                            && !next_st.bus.bvalid;
      next_st.bus.wready = !next_st.wHeld
                           && !next_st.bus.bvalid;
      next_st.bus.arready = !next_st.bus.rvalid;
   end

   // State register; constants only under reset
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st <= '0;
         st.bitSel <= `TSR_RST_BITSEL;
         st.groupCtl <= `TSR_RST_GROUPCTL;
         st.pinEn <= `TSR_RST_PINEN;
         st.auxSel <= `TSR_RST_AUXSEL;
         st.hostMode <= HOST_PARALLEL;
         // Generators seed to all ones so the first bits are known
         st.prbs9 <= `TSR_SEED9;
         st.prbs15 <= `TSR_SEED15;
         // Line enable resets to one
         st.pins.uartLinesOe <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state flip-flops
   assign axiResp = st.bus;
   assign pins = st.pins;
endmodule

// ### rtl/tsr_defines.svh
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH
// Register indices; byte address is four times the index
`define TSR_IDX_RESERVED 8'h30
`define TSR_IDX_BITSEL 8'h31
`define TSR_IDX_GROUPCTL 8'h32
`define TSR_IDX_PINEN 8'h33
`define TSR_IDX_BUSREAD 8'h35
`define TSR_IDX_AUXCTL 8'h3a
// Reset values
`define TSR_RST_BITSEL 3'h0
`define TSR_RST_GROUPCTL 8'h00
`define TSR_RST_PINEN 8'h80
`define TSR_RST_AUXSEL 4'h0
// Field positions
`define TSR_F_SWAP 7
`define TSR_F_PRBS9 6
`define TSR_F_PRBS15 5
`define TSR_F_LINEEN 7
`define TSR_F_TXCMD 6
// Second auxiliary select value that routes the test bit
`define TSR_AUXILIARY_PIN_TWO_TESTBIT 4'hf
// Data pins usable while SPI, or UART with line enable set, shares the port
`define TSR_PINS_LIMITED 6'h0f
`define TSR_PINS_ALL 6'h3f
// Sequence seeds
`define TSR_SEED9 9'h1ff
`define TSR_SEED15 15'h7fff
// Bus responses
`define TSR_RESP_OKAY 2'h0
`define TSR_RESP_SLVERR 2'h2
`endif

// ### rtl/tsr_pkg.sv
package tsr_pkg;
   // Host interface in use
   typedef enum logic [1:0] {
      HOST_PARALLEL = 2'b00,
      HOST_SPI = 2'b01,
      HOST_UART = 2'b10,
      HOST_I2C = 2'b11
   } tsr_host_type;
   // Decoded register
   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_RESERVED = 3'b001,
      SEL_BITSEL = 3'b010,
      SEL_GROUPCTL = 3'b011,
      SEL_PINEN = 3'b100,
      SEL_BUSREAD = 3'b101,
      SEL_AUXCTL = 3'b110
   } tsr_sel_type;
   // Thirty-two internal groups of eight test signals
   typedef logic [31:0][7:0] tsr_groups_type;
   // AXI4-Lite master to slave
   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } tsr_axi_req_type;
   // AXI4-Lite slave to master
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tsr_axi_resp_type;
   // Pin side outputs
   typedef struct packed {
      logic modulationOutputPin;
      logic auxiliaryPinTwo;
      logic auxiliaryPinTwoOe;
      logic [5:0] dataPinOut;
      logic [5:0] dataPinOe;
      logic uartExtraOutputLine;
      logic uartRequestLine;
      logic uartLinesOe;
      logic prbsBit;
      logic prbsActive;
   } tsr_pins_type;
endpackage

// ### sim/tsr_pin_probe.sv
`timescale 1ns/1ps
// Test equipment on the data pins; no pull on any of them
module tsr_pin_probe (
   input wire logic clk_sys,
   input wire logic [5:0] dataPinOut,
   input wire logic [5:0] dataPinOe,
   output logic [5:0] seen
);
   logic [5:0] last = 6'h00; // Level seen a cycle ago
   logic [5:0] next_last;
   // A released pin floats, so show a level that keeps moving
   always_comb begin
      seen = (dataPinOut & dataPinOe) | (~last & ~dataPinOe);
      next_last = seen;
   end
   // Remember the level for the next cycle
   always_ff @(posedge clk_sys) begin
      last <= next_last;
   end
endmodule

// ### sim/tsr_check_asserts.sv
`timescale 1ns/1ps
module tsr_check (
   input wire logic clk_sys,
   input wire logic reset,
   input wire tsr_pkg::tsr_axi_req_type axiReq,
   input wire tsr_pkg::tsr_axi_resp_type axiResp,
   input wire tsr_pkg::tsr_groups_type testGroups,
   input wire logic uartExtraData,
   input wire logic uartRequestData,
   input wire tsr_pkg::tsr_pins_type pins
);
   import tsr_pkg::*;
   // Register shadow, one clock behind the design like the pins
   typedef struct packed {
      tsr_groups_type prev; // Groups as last sampled
      logic [31:0] addr; // Write address taken
      logic [8:0] wd; // Strobe and data byte
      logic lastB; // Response seen last cycle
      logic [1:0] cnt; // Edges since reset
      logic [7:0] bitSel;
      logic [7:0] grp;
      logic [7:0] pinEn;
      logic [7:0] aux;
   } tsr_chk_type;
   tsr_chk_type st, next_st;
   logic [7:0] bus; // Selected group
   logic [5:0] lim; // Usable data pins
   logic live; // Shadow trustworthy
   assign bus = st.prev[st.grp[4:0]];
   assign lim = (st.aux[5:4] == 2'h1 || (st.aux[5:4] == 2'h2 && st.pinEn[7]))
      ? 6'h0f : 6'h3f;
   assign live = st.cnt == 2'h2;
   // Follow handshakes; a write lands as its response rises
   always_comb begin
      next_st = st;
      next_st.prev = testGroups;
      next_st.lastB = axiResp.bvalid;
      if (!live) next_st.cnt = st.cnt + 2'h1;
      if (axiReq.awvalid && axiResp.awready) next_st.addr = axiReq.awaddr;
      if (axiReq.wvalid && axiResp.wready) begin
         next_st.wd = {axiReq.wstrb[0], axiReq.wdata[7:0]};
      end
      if (axiResp.bvalid && !st.lastB && st.wd[8]) begin
         case (st.addr)
            32'hc4: next_st.bitSel = st.wd[7:0];
            32'hc8: next_st.grp = st.wd[7:0];
            32'hcc: next_st.pinEn = st.wd[7:0];
            32'he8: next_st.aux = st.wd[7:0];
            default: ; // Unmapped or ignored
         endcase
      end
   end
   // Shadow restarts with the design
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st <= '0;
         st.pinEn <= 8'h80;
      end else begin
         st <= next_st;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Transmit command completing, with a sequence mode set
   sequence txCmd;
      $rose(axiResp.bvalid) && st.addr == 32'he8 && st.wd[6] && st.wd[8]
         && (st.grp[6] || st.grp[5]);
   endsequence
   mod_pin_a: assert property (
      live |-> pins.modulationOutputPin == bus[st.bitSel[2:0]])
      else $error("modulation pin wrong");
   aux_enable_a: assert property (
      live |-> pins.auxiliaryPinTwoOe == (st.aux[3:0] == 4'hf))
      else $error("aux enable wrong");
   aux_bit_a: assert property (
      live && pins.auxiliaryPinTwoOe
      |-> pins.auxiliaryPinTwo == bus[st.bitSel[2:0]])
      else $error("aux value wrong");
   data_order_a: assert property (
      live |-> pins.dataPinOut == (st.grp[7]
      ? {bus[0], bus[5], bus[6], bus[2], bus[3], bus[4]} : bus[6:1]))
      else $error("data pin order wrong");
   pin_enable_a: assert property (
      live |-> pins.dataPinOe == (st.pinEn[6:1] & lim))
      else $error("data pin enable wrong");
   uart_off_a: assert property (
      live && !st.pinEn[7] |-> !(pins.uartLinesOe || pins.uartExtraOutputLine
      || pins.uartRequestLine)) else $error("uart lines not off");
   tx_start_a: assert property (
      $rose(pins.prbsActive) |-> txCmd) else $error("sequence began unasked");
   tx_stop_a: assert property (
      live && !st.grp[6] && !st.grp[5] |-> !pins.prbsActive)
      else $error("sequence runs with no mode");
endmodule
bind tsr_test_signal_routing tsr_check u_tsr_check (.clk_sys(clk_sys),
   .reset(reset), .axiReq(axiReq), .axiResp(axiResp),
   .testGroups(testGroups), .uartExtraData(uartExtraData),
   .uartRequestData(uartRequestData), .pins(pins));

// ### sim/test_test_signal_routing.sv
`timescale 1ns/1ps
module test_test_signal_routing;
   import tsr_pkg::*;
   logic clk_sys = 1'b0; // 40 MHz
   logic reset = 1'b1;
   tsr_axi_req_type axiReq = '0; // Bus master side
   tsr_axi_resp_type axiResp;
   tsr_groups_type testGroups; // Fixed patterns
   logic uartExtraData = 1'b1;
   logic uartRequestData = 1'b1;
   tsr_pins_type pins;
   logic [5:0] seen; // Data pins at the probe
   logic [31:0] rd; // Last read word
   logic [1:0] rsp; // Last response
   logic [47:0] seq; // Captured sequence
   logic [7:0] b; // Expected test bus
   int n_mismatch = 0;
   int checks_done = 0;
   tsr_test_signal_routing u_tsr_test_signal_routing (.clk_sys(clk_sys),
      .reset(reset), .axiReq(axiReq), .axiResp(axiResp),
      .testGroups(testGroups), .uartExtraData(uartExtraData),
      .uartRequestData(uartRequestData), .pins(pins));
   tsr_pin_probe u_tsr_pin_probe (.clk_sys(clk_sys),
      .dataPinOut(pins.dataPinOut), .dataPinOe(pins.dataPinOe), .seen(seen));
   // Free-running clock
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   // One compare for every result
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Write: both channels offered, each dropped once taken
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr <= a;
      axiReq.wvalid <= 1'b1;
      axiReq.wdata <= {24'h0, d};
      axiReq.wstrb <= 4'hf;
      forever begin
         @(posedge clk_sys);
         if (axiReq.awvalid && axiResp.awready) axiReq.awvalid <= 1'b0;
         if (axiReq.wvalid && axiResp.wready) axiReq.wvalid <= 1'b0;
         if (axiResp.bvalid) break;
      end
      rsp = axiResp.bresp;
   endtask
   // Read; rready stays high all run
   task automatic rdw(input logic [31:0] a);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr <= a;
      forever begin
         @(posedge clk_sys);
         if (axiReq.arvalid && axiResp.arready) axiReq.arvalid <= 1'b0;
         if (axiResp.rvalid) break;
      end
      rd = axiResp.rdata;
      rsp = axiResp.rresp;
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] e);
      rdw(a);
      cmp(rd, e);
   endtask
   // Pins trail a write by one clock
   task automatic settle;
      repeat (2) @(posedge clk_sys);
   endtask
   // Breaks of a recurrence s[k] = s[k-n] ^ s[k-t]
   function automatic int brk(input int n, input int t);
      brk = 0;
      for (int k = n; k < 48; k++) begin
         brk += int'(seq[k] != (seq[k-n] ^ seq[k-t]));
      end
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Far longer than the tests need
   initial begin
      #400000;
      n_mismatch++;
      stop_test;
   end
   initial begin
      for (int g = 0; g < 32; g++) testGroups[g] = 8'(g * 29) ^ 8'h96;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      axiReq.bready <= 1'b1;
      axiReq.rready <= 1'b1;
      @(posedge clk_sys);
      // Reset values, reserved bits and an unmapped place
      rchk(32'hc0, 32'h00);
      rchk(32'hc8, 32'h00);
      rchk(32'hcc, 32'h80);
      wr(32'hc0, 8'hff);
      rchk(32'hc0, 32'h00);
      wr(32'hc4, 8'hff);
      rchk(32'hc4, 32'h07);
      wr(32'hcc, 8'h7f);
      rchk(32'hcc, 32'h7e);
      rdw(32'h100);
      cmp(32'(rsp), 32'h2);
      $display("test registers finished");
      // Each bit select with its own group, plain then swapped
      for (int i = 0; i < 8; i++) begin
         b = testGroups[i*4+3];
         wr(32'hc8, 8'(i * 4 + 3));
         wr(32'hc4, 8'(i));
         settle;
         cmp(32'(pins.modulationOutputPin), 32'(b[i]));
         cmp(32'(seen), 32'(b[6:1]));
         rchk(32'hd4, 32'(b));
         wr(32'hc8, 8'(i * 4 + 3) | 8'h80);
         settle;
         cmp(32'(seen), {26'h0, b[0], b[5], b[6], b[2], b[3], b[4]});
      end
      wr(32'he8, 8'h0f);
      settle;
      cmp(32'(pins.auxiliaryPinTwoOe), 32'h1);
      cmp(32'(pins.auxiliaryPinTwo), 32'(b[7]));
      $display("test routing finished");
      // Every host mode, line enable off and on
      for (int h = 0; h < 8; h++) begin
         uartExtraData <= h[1];
         wr(32'hcc, {h[0], 7'h7e});
         wr(32'he8, {2'h0, h[2:1], 4'h0});
         settle;
         b = (h / 2 == 1 || h == 5) ? 8'h0f : 8'h3f;
         cmp(32'(pins.dataPinOe), 32'(b));
         cmp(32'(pins.uartLinesOe), 32'(h[0]));
         cmp(32'(pins.uartExtraOutputLine), 32'(h[0] & h[1]));
         cmp(32'(pins.uartRequestLine), 32'(h[0]));
      end
      wr(32'hcc, 8'h2a);
      wr(32'he8, 8'h00);
      settle;
      cmp(32'(pins.dataPinOe), 32'h15);
      $display("test pins finished");
      // Both sequence lengths; taps of either bit order accepted
      for (int m = 0; m < 2; m++) begin
         wr(32'hc8, m ? 8'h20 : 8'h40);
         settle;
         cmp(32'(pins.prbsActive), 32'h0);
         wr(32'he8, 8'h40);
         for (int k = 0; k < 48; k++) begin
            @(posedge clk_sys);
            seq[k] = pins.prbsBit;
         end
         cmp(32'(pins.prbsActive), 32'h1);
         cmp(32'(seq[0]), 32'h1);
         if (m) cmp(32'(brk(15, 14) * brk(15, 1)), 0);
         else cmp(32'(brk(9, 5) * brk(9, 4)), 0);
         wr(32'hc8, 8'h00);
         settle;
         cmp(32'(pins.prbsActive), 32'h0);
      end
      $display("test sequences finished");
      stop_test;
   end
endmodule
